// File: alarm_channel.sv
`timescale 1ns/10ps
module alarm_channel
  import alarm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Configuration
  input wire chan_cfg_t cfg,
  // Selected source sample
  input wire logic smp_valid,
  input wire logic [DATA_W-1:0] smp_data,
  // One-cycle alarm event
  output logic hit
);

  logic [DATA_W-1:0] prev_reg;
  logic have_prev_reg;
  logic signed [ACC_W-1:0] acc_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] n_eff;
  logic signed [ACC_W-1:0] cur_w;
  logic signed [ACC_W-1:0] prev_w;
  logic signed [ACC_W-1:0] level_w;
  logic signed [ACC_W-1:0] n_w;
  logic signed [ACC_W-1:0] thr;
  logic signed [ACC_W-1:0] acc_next;
  logic last;
  logic static_cmp;
  logic slope_cmp;

  // A zero count would close the window on every sample against a zero threshold; treat it as one
  assign n_eff = (cfg.count == '0) ? 8'h01 : cfg.count;
  assign cur_w = {{(ACC_W-DATA_W){smp_data[DATA_W-1]}}, smp_data};
  assign prev_w = {{(ACC_W-DATA_W){prev_reg[DATA_W-1]}}, prev_reg};
  assign level_w = {{(ACC_W-DATA_W){cfg.level[DATA_W-1]}}, cfg.level};
  assign n_w = {{(ACC_W-CNT_W){1'b0}}, n_eff};
  // Sum against level times count avoids a divider for the average
  assign thr = level_w * n_w;
  assign acc_next = acc_reg + (cur_w - prev_w);
  assign last = ({1'b0, cnt_reg} + 9'h001) >= {1'b0, n_eff};
  assign static_cmp = cfg.greater ? (cur_w > level_w) :
                                    (cur_w < level_w);
  assign slope_cmp = cfg.greater ? (acc_next > thr) :
                                   (acc_next < thr);

  always_ff @(posedge clk_sys) begin
    if (srst || !cfg.enable) begin
      prev_reg <= '0;
      have_prev_reg <= 1'b0;
      acc_reg <= '0;
      cnt_reg <= '0;
    end else if (smp_valid) begin
      prev_reg <= smp_data;
      have_prev_reg <= 1'b1;
      if (cfg.slope && have_prev_reg) begin
        if (last) begin
          acc_reg <= '0;
          cnt_reg <= '0;
        end else begin
          acc_reg <= acc_next;
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hit <= 1'b0;
    end else begin
      hit <= cfg.enable && smp_valid &&
             (cfg.slope ? (have_prev_reg && last && slope_cmp)
                        : static_cmp);
    end
  end

  property p_static_hit;
    @(posedge clk_sys) disable iff (srst)
      (cfg.enable && !cfg.slope && smp_valid && static_cmp) |=> hit;
  endproperty
  a_static_hit: assert property (p_static_hit)
    else $error("static compare did not raise alarm");

  property p_hit_needs_sample;
    @(posedge clk_sys) disable iff (srst)
      hit |-> $past(smp_valid) && $past(cfg.enable);
  endproperty
  a_hit_needs_sample: assert property (p_hit_needs_sample)
    else $error("alarm without a fresh sample");

  property p_first_no_delta;
    @(posedge clk_sys) disable iff (srst)
      (cfg.slope && smp_valid && !have_prev_reg) |=> !hit;
  endproperty
  a_first_no_delta: assert property (p_first_no_delta)
    else $error("slope alarm before any delta exists");

  property p_slope_window;
    @(posedge clk_sys) disable iff (srst)
      (cfg.enable && cfg.slope && smp_valid && have_prev_reg && !last)
        |=> !hit && (cnt_reg == $past(cnt_reg) + 8'h01);
  endproperty
  a_slope_window: assert property (p_slope_window)
    else $error("slope window closed early");

  c_slope_hit: cover property (@(posedge clk_sys) disable iff (srst)
    cfg.slope ##1 hit);
  c_static_hit: cover property (@(posedge clk_sys) disable iff (srst)
    !cfg.slope ##1 hit);

endmodule : alarm_channel

// File: alarm_comparator.sv
`timescale 1ns/10ps
module alarm_comparator
  import alarm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port from the serial interface
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Source samples from the signal chain
  input wire sample_t [NSRC-1:0] src_in,
  // General-purpose pins, enable low while driving
  output logic general_pin_one,
  output logic general_pin_one_oe_n,
  output logic general_pin_two,
  output logic general_pin_two_oe_n,
  // Alarm state
  output logic [NALM-1:0] alarm_flags
);

  logic [15:0] magnitude_reg [NALM];
  logic [15:0] sample_count_reg [NALM];
  logic [15:0] alarm_control_reg;
  logic [NALM-1:0] flags_reg;
  logic [NALM-1:0] hit;
  logic status_rd;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] val,
                                        input logic [1:0] be,
                                        input logic [15:0] mask);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = val[7:0];
    end
    if (be[1]) begin
      r[15:8] = val[15:8];
    end
    return r & mask;
  endfunction : merge

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      magnitude_reg[0] <= REG_RESET;
      magnitude_reg[1] <= REG_RESET;
      sample_count_reg[0] <= REG_RESET;
      sample_count_reg[1] <= REG_RESET;
      alarm_control_reg <= REG_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        MAG1_OFF: begin
          magnitude_reg[0] <= merge(magnitude_reg[0], wr_data, wr_be,
                                    MAG_MASK);
        end
        MAG2_OFF: begin
          magnitude_reg[1] <= merge(magnitude_reg[1], wr_data, wr_be,
                                    MAG_MASK);
        end
        SMPL1_OFF: begin
          sample_count_reg[0] <= merge(sample_count_reg[0], wr_data,
                                       wr_be, SMPL_MASK);
        end
        SMPL2_OFF: begin
          sample_count_reg[1] <= merge(sample_count_reg[1], wr_data,
                                       wr_be, SMPL_MASK);
        end
        CTRL_OFF: begin
          alarm_control_reg <= merge(alarm_control_reg, wr_data, wr_be,
                                     CTRL_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  assign status_rd = rd_en && (rd_addr == STATUS_OFF);

  // Read data is registered; unmapped offsets answer zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      case (rd_addr)
        MAG1_OFF: begin
          rd_data <= magnitude_reg[0];
        end
        MAG2_OFF: begin
          rd_data <= magnitude_reg[1];
        end
        SMPL1_OFF: begin
          rd_data <= sample_count_reg[0];
        end
        SMPL2_OFF: begin
          rd_data <= sample_count_reg[1];
        end
        CTRL_OFF: begin
          rd_data <= alarm_control_reg;
        end
        STATUS_OFF: begin
          rd_data <= '0;
          rd_data[STAT_ALM1_BIT] <= flags_reg[0];
          rd_data[STAT_ALM2_BIT] <= flags_reg[1];
        end
        default: begin
          rd_data <= '0;
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NALM; g++) begin : g_alarm
      logic [2:0] sel;
      logic slope;
      logic use_filt;
      logic smp_valid;
      logic [DATA_W-1:0] smp_data;
      chan_cfg_t cfg;

      if (g == 0) begin : g_first
        assign sel = alarm_control_reg[CTRL_SRC1_LSB +: 3];
        assign slope = alarm_control_reg[CTRL_SLOPE1_BIT];
      end else begin : g_second
        assign sel = alarm_control_reg[CTRL_SRC2_LSB +: 3];
        assign slope = alarm_control_reg[CTRL_SLOPE2_BIT];
      end
      assign use_filt = alarm_control_reg[CTRL_FILT_BIT];

      always_comb begin
        smp_valid = 1'b0;
        smp_data = '0;
        // Inactive codes behave like disable
        case (sel)
          SRC_SUPPLY: begin
            smp_valid = src_in[SI_SUPPLY].valid;
            smp_data = use_filt ? src_in[SI_SUPPLY].filt
                                : src_in[SI_SUPPLY].raw;
          end
          SRC_GYRO: begin
            smp_valid = src_in[SI_GYRO].valid;
            smp_data = use_filt ? src_in[SI_GYRO].filt
                                : src_in[SI_GYRO].raw;
          end
          SRC_AUX: begin
            smp_valid = src_in[SI_AUX].valid;
            smp_data = use_filt ? src_in[SI_AUX].filt
                                : src_in[SI_AUX].raw;
          end
          SRC_TEMP: begin
            smp_valid = src_in[SI_TEMP].valid;
            smp_data = use_filt ? src_in[SI_TEMP].filt
                                : src_in[SI_TEMP].raw;
          end
          default: begin
          end
        endcase
      end

      always_comb begin
        cfg.enable = (sel == SRC_SUPPLY) || (sel == SRC_GYRO) ||
                     (sel == SRC_AUX) || (sel == SRC_TEMP);
        cfg.slope = slope;
        cfg.greater = magnitude_reg[g][MAG_DIR_BIT];
        cfg.level = magnitude_reg[g][MAG_DATA_MSB:0];
        cfg.count = sample_count_reg[g][SMPL_MSB:0];
      end

      alarm_channel alarm_channel_inst (
        .clk_sys(clk_sys),
        .srst(srst),
        .cfg(cfg),
        .smp_valid(smp_valid),
        .smp_data(smp_data),
        .hit(hit[g])
      );
    end
  endgenerate

  // A hit in the same cycle as the status read survives the clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags_reg <= '0;
    end else if (status_rd) begin
      flags_reg <= hit;
    end else begin
      flags_reg <= flags_reg | hit;
    end
  end

  assign alarm_flags = flags_reg;

  // Pin level follows the flags one cycle later
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      general_pin_one <= 1'b0;
      general_pin_two <= 1'b0;
      general_pin_one_oe_n <= 1'b1;
      general_pin_two_oe_n <= 1'b1;
    end else begin
      general_pin_one <= (|flags_reg) ~^
                         alarm_control_reg[CTRL_OUT_POL_BIT];
      general_pin_two <= (|flags_reg) ~^
                         alarm_control_reg[CTRL_OUT_POL_BIT];
      general_pin_one_oe_n <= !(alarm_control_reg[CTRL_OUT_EN_BIT] &&
                                !alarm_control_reg[CTRL_OUT_SEL_BIT]);
      general_pin_two_oe_n <= !(alarm_control_reg[CTRL_OUT_EN_BIT] &&
                                alarm_control_reg[CTRL_OUT_SEL_BIT]);
    end
  end

  property p_set_wins;
    @(posedge clk_sys) disable iff (srst)
      hit[0] |=> flags_reg[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("alarm event lost");

  property p_read_clears;
    @(posedge clk_sys) disable iff (srst)
      // Status contents only stand while the read address still points at it
      (status_rd && hit == '0) |=> flags_reg == '0 ##1
        ($past(rd_addr) != STATUS_OFF || rd_data == '0);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear flags");

  property p_status_bits;
    @(posedge clk_sys) disable iff (srst)
      status_rd |=> rd_valid && rd_data[STAT_ALM2_BIT] == $past(flags_reg[1])
        && rd_data[STAT_ALM1_BIT] == $past(flags_reg[0]);
  endproperty
  a_status_bits: assert property (p_status_bits)
    else $error("status bits misreport alarms");

  property p_pin_route;
    @(posedge clk_sys) disable iff (srst)
      alarm_control_reg[CTRL_OUT_EN_BIT] |=>
        (general_pin_one_oe_n != general_pin_two_oe_n) &&
        (general_pin_two_oe_n == !$past(alarm_control_reg[CTRL_OUT_SEL_BIT]));
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("alarm routed to the wrong pin");

  property p_pin_level;
    @(posedge clk_sys) disable iff (srst)
      (|flags_reg && alarm_control_reg[CTRL_OUT_POL_BIT]) |=>
        general_pin_one && general_pin_two;
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("active-high alarm pin not high");

  property p_pin_off;
    @(posedge clk_sys) disable iff (srst)
      !alarm_control_reg[CTRL_OUT_EN_BIT] |=>
        general_pin_one_oe_n && general_pin_two_oe_n;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("alarm pin driven while disabled");

  c_read_clear: cover property (@(posedge clk_sys) disable iff (srst)
    flags_reg[1] ##1 status_rd ##1 !flags_reg[1]);
  c_pin_two: cover property (@(posedge clk_sys) disable iff (srst)
    !general_pin_two_oe_n && |flags_reg);
  c_both: cover property (@(posedge clk_sys) disable iff (srst)
    flags_reg == 2'h3);

endmodule : alarm_comparator

// File: alarm_pkg.sv
package alarm_pkg;

  // Sample and register widths
  localparam int DATA_W = 14;
  localparam int REG_W = 16;
  localparam int CNT_W = 8;
  localparam int ACC_W = 24;
  localparam int NSRC = 4;
  localparam int NALM = 2;

  // Register byte offsets
  localparam logic [7:0] MAG1_OFF = 8'h20;
  localparam logic [7:0] MAG2_OFF = 8'h22;
  localparam logic [7:0] SMPL1_OFF = 8'h24;
  localparam logic [7:0] SMPL2_OFF = 8'h26;
  localparam logic [7:0] CTRL_OFF = 8'h28;
  localparam logic [7:0] STATUS_OFF = 8'h3C;

  localparam logic [15:0] REG_RESET = 16'h0000;

  // Writable bits; the rest read as zero
  localparam logic [15:0] MAG_MASK = 16'hBFFF;
  localparam logic [15:0] SMPL_MASK = 16'h00FF;
  localparam logic [15:0] CTRL_MASK = 16'hFF17;

  // Field positions
  localparam int MAG_DIR_BIT = 15;
  localparam int MAG_DATA_MSB = 13;
  localparam int SMPL_MSB = 7;
  localparam int CTRL_SLOPE2_BIT = 15;
  localparam int CTRL_SRC2_LSB = 12;
  localparam int CTRL_SLOPE1_BIT = 11;
  localparam int CTRL_SRC1_LSB = 8;
  localparam int CTRL_FILT_BIT = 4;
  localparam int CTRL_OUT_EN_BIT = 2;
  localparam int CTRL_OUT_POL_BIT = 1;
  localparam int CTRL_OUT_SEL_BIT = 0;
  localparam int STAT_ALM1_BIT = 8;
  localparam int STAT_ALM2_BIT = 9;

  // Source input indices
  localparam int SI_SUPPLY = 0;
  localparam int SI_GYRO = 1;
  localparam int SI_AUX = 2;
  localparam int SI_TEMP = 3;

  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_SUPPLY = 3'h1,
    SRC_GYRO = 3'h2,
    SRC_AUX = 3'h5,
    SRC_TEMP = 3'h6
  } src_sel_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] raw;
    logic [DATA_W-1:0] filt;
  } sample_t;

  typedef struct packed {
    logic enable;
    logic slope;
    logic greater;
    logic [DATA_W-1:0] level;
    logic [CNT_W-1:0] count;
  } chan_cfg_t;

endpackage : alarm_pkg

// File: dual_sensor_alarm_comparator_bench.sv
`timescale 1ns/10ps
module dual_sensor_alarm_comparator_bench;
  import alarm_pkg::*;
  logic clk_sys;
  logic srst;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [1:0] wr_be;
  logic [15:0] wr_data;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [15:0] rd_data;
  logic rd_valid;
  sample_t [NSRC-1:0] src;
  logic pin1;
  logic oe1_n;
  logic pin2;
  logic oe2_n;
  logic [NALM-1:0] alarm_flags;
  int n_fail;
  int checked;
  logic [15:0] v;
  logic ok;
  logic [7:0] offs [5] = '{MAG1_OFF, MAG2_OFF, SMPL1_OFF, SMPL2_OFF,
                           CTRL_OFF};
  logic [15:0] masks [5] = '{MAG_MASK, MAG_MASK, SMPL_MASK, SMPL_MASK,
                             CTRL_MASK};
  // Source index per code, 4 meaning none
  int src_of [8] = '{4, 0, 1, 4, 4, 2, 3, 4};

  alarm_comparator alarm_comparator_inst (
    .clk_sys(clk_sys), .srst(srst), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_be(wr_be), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .src_in(src),
    .general_pin_one(pin1), .general_pin_one_oe_n(oe1_n),
    .general_pin_two(pin2), .general_pin_two_oe_n(oe2_n),
    .alarm_flags(alarm_flags)
  );

  host_port host_port_inst (
    .clk_sys(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr), .wr_be(wr_be),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [15:0] d);
    host_port_inst.wr(a, d, 2'h3);
  endtask : w

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    host_port_inst.rd(a, v, ok);
    if (!ok) begin
      n_fail++;
      close_out();
    end else begin
      chk(v, exp);
    end
  endtask : rchk

  task automatic fchk(input logic [1:0] exp);
    chk({14'h0000, alarm_flags}, {14'h0000, exp});
  endtask : fchk

  // Pulse valid on the chosen sources, then let the result settle
  task automatic pulse(input logic [3:0] which, input logic [13:0] r,
                       input logic [13:0] f);
    @(posedge clk_sys);
    for (int k = 0; k < NSRC; k++) src[k] <= {which[k], r, f};
    @(posedge clk_sys);
    for (int k = 0; k < NSRC; k++) src[k].valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : pulse

  task automatic clr;
    host_port_inst.rd(STATUS_OFF, v, ok);
  endtask : clr

  initial begin
    srst = 1'b1;
    src = '0;
    n_fail = 0;
    checked = 0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) rchk(offs[i], REG_RESET);
    rchk(STATUS_OFF, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      w(offs[i], 16'hFFFF);
      rchk(offs[i], masks[i]);
    end
    rchk(8'h2A, 16'h0000);
    host_port_inst.wr(CTRL_OFF, 16'h0000, 2'h1);
    rchk(CTRL_OFF, 16'hFF00);
    for (int i = 0; i < 5; i++) w(offs[i], 16'h0000);
    // Static compare is strict: equal to the level must not fire
    w(MAG1_OFF, 16'h8010);
    w(CTRL_OFF, 16'h0100);
    pulse(4'h1, 14'h0010, 14'h0000);
    fchk(2'h0);
    pulse(4'h1, 14'h0011, 14'h0000);
    fchk(2'h1);
    rchk(STATUS_OFF, 16'h0100);
    rchk(STATUS_OFF, 16'h0000);
    w(MAG2_OFF, 16'h0005);
    w(CTRL_OFF, 16'h2010);
    pulse(4'h2, 14'h0003, 14'h0064);
    fchk(2'h0);
    pulse(4'h2, 14'h0064, 14'h0003);
    fchk(2'h2);
    clr();
    w(MAG2_OFF, 16'h8010);
    for (int a = 0; a < 2; a++) begin
      for (int c = 0; c < 8; c++) begin
        w(CTRL_OFF, a ? {1'b0, c[2:0], 12'h000} : {5'h00, c[2:0], 8'h00});
        for (int k = 0; k < NSRC; k++) begin
          pulse(4'(1 << k), 14'h0011, 14'h0011);
          fchk((src_of[c] == k) ? 2'(1 << a) : 2'h0);
          clr();
        end
      end
    end
    // Two deltas of 4 average 4, above 3; a single delta must not decide
    w(MAG1_OFF, 16'h8003);
    w(SMPL1_OFF, 16'h0002);
    w(CTRL_OFF, 16'h0900);
    pulse(4'h1, 14'h0000, 14'h0000);
    pulse(4'h1, 14'h0004, 14'h0000);
    fchk(2'h0);
    pulse(4'h1, 14'h0008, 14'h0000);
    fchk(2'h1);
    clr();
    w(MAG2_OFF, 16'h0000);
    w(SMPL2_OFF, 16'h0001);
    w(CTRL_OFF, 16'h9000);
    pulse(4'h1, 14'h0005, 14'h0000);
    pulse(4'h1, 14'h0002, 14'h0000);
    fchk(2'h2);
    for (int m = 0; m < 4; m++) begin
      w(CTRL_OFF, 16'h9004 | 16'(m));
      repeat (4) @(posedge clk_sys);
      #1;
      chk({oe1_n, oe2_n, m[0] ? pin2 : pin1},
          {m[0] ? 2'b10 : 2'b01, m[1]});
    end
    w(CTRL_OFF, 16'h9000);
    repeat (4) @(posedge clk_sys);
    #1;
    chk({oe1_n, oe2_n}, 2'b11);
    clr();
    w(CTRL_OFF, 16'h9006);
    repeat (4) @(posedge clk_sys);
    #1;
    chk({oe1_n, pin1}, 2'b00);
    close_out();
  end
endmodule : dual_sensor_alarm_comparator_bench

// File: host_port.sv
`timescale 1ns/10ps
module host_port (
  // Clock
  input wire logic clk_sys,
  // Register port toward the block
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [1:0] wr_be,
  output logic [15:0] wr_data,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_be = 2'h0;
    wr_data = 16'h0000;
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] be);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_be <= be;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    // Scramble released data so a stale value cannot pass for a held one
    wr_data <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic ok);
    int i;
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk_sys);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rd_data;
      end else begin
        @(posedge clk_sys);
      end
    end
  endtask : rd
endmodule : host_port
